// file: common/port_d_mux_consts.vh
// Constants for the port D alternate function multiplexer.
`ifndef PORT_D_MUX_CONSTS_VH
`define PORT_D_MUX_CONSTS_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define PORT_WIDTH 8
`define AXI_ADDR_WIDTH 8
`define AXI_DATA_WIDTH 32
`define AXI_STRB_WIDTH 4

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_OUT_VALUE 8'h00
`define OFS_DIRECTION 8'h04
`define OFS_PIN_INPUT 8'h08
`define OFS_CONTROL 8'h0C
`define OFS_PC_MASK 8'h10

// ----------------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_PUD_BIT 0
`define CTRL_PCIE_BIT 1
`define RST_OUT_VALUE 8'h00
`define RST_DIRECTION 8'h00
`define RST_PC_MASK 8'h00
`define RST_CONTROL 2'h0

// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------------------
// Pin assignment within the port
// ----------------------------------------------------------------------------
`define BIT_T2_CMP_A 7
`define BIT_T2_CMP_B 6
`define BIT_T1_CAPTURE 6
`define BIT_T1_CMP_A 5
`define BIT_T1_CMP_B 4
`define BIT_S1_XCLK 4
`define BIT_IRQ1 3
`define BIT_S1_TX 3
`define BIT_IRQ0 2
`define BIT_S1_RX 2
`define BIT_S0_TX 1
`define BIT_S0_RX 0
`define PIN_CHANGE_BASE 24

`endif

// file: rtl/sync_two_stage.v
// Two flip-flop synchroniser for the port pin levels.
`timescale 1ns/1ns
`default_nettype none
`include "port_d_mux_consts.vh"

module sync_two_stage (
  input wire aclk,
  input wire aresetn,
  input wire [`PORT_WIDTH-1:0] async_in,
  output wire [`PORT_WIDTH-1:0] sync_out
);

  reg [`PORT_WIDTH-1:0] stage1_ff;
  reg [`PORT_WIDTH-1:0] stage2_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1_ff <= {`PORT_WIDTH{1'b0}};
      stage2_ff <= {`PORT_WIDTH{1'b0}};
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;

endmodule // sync_two_stage

`default_nettype wire

// file: rtl/pin_override_cell.v
// Generic per-pin override logic: direction, value, pull-up and input enable.
`timescale 1ns/1ns
`default_nettype none

module pin_override_cell (
  input wire dir_reg,
  input wire out_reg,
  input wire global_pullup_disable,
  input wire sleep_input_disable,
  input wire pullup_override_enable,
  input wire pullup_override_value,
  input wire direction_override_enable,
  input wire direction_override_value,
  input wire port_value_override_enable,
  input wire port_value_override_value,
  input wire input_enable_override_enable,
  input wire input_enable_override_value,
  input wire pin_level,
  output wire pin_dir,
  output wire pin_value,
  output wire pin_pullup,
  output wire pin_input
);

  wire input_enable;

  // Each override pair replaces only its own signal; the rest come from the port registers, and input enable from the sleep input disable.
  assign pin_dir = direction_override_enable ? direction_override_value : dir_reg;
  assign pin_value = port_value_override_enable ? port_value_override_value : out_reg;
  // Pull-up only for an input with its value bit set, and never while globally disabled.
  assign pin_pullup = pullup_override_enable ? pullup_override_value :
                      (~dir_reg & out_reg & ~global_pullup_disable);
  assign input_enable = input_enable_override_enable ? input_enable_override_value : ~sleep_input_disable;
  assign pin_input = pin_level & input_enable;

endmodule // pin_override_cell

`default_nettype wire

// file: rtl/port_d_alternate_function_mux.v
// Port D alternate function multiplexer with its AXI4-Lite port registers.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "port_d_mux_consts.vh"

// Summary of operation
// - Bit 7 drives timer-two compare A only while its direction bit is one.
// - Compare pins also carry PWM waveforms, under the same routing and direction.
// - Bit 6 drives timer-two compare B when its direction bit is one.
// - Bit 5 drives timer-one compare A when its direction bit is one.
// - Bit 4 drives timer-one compare B when its direction bit is one.
// - Synchronised bit 6 input feeds timer-one capture as well as pin change.
// - Bit 4 is serial one external clock, as input or as output.
// - Bit 3 feeds interrupt line one; its input stays enabled while enabled.
// - Bit 2 feeds interrupt line zero; its input stays enabled while enabled.
// - Transmitter one forces bit 3 to output with its data, pull-up off.
// - Receiver one forces bit 2 to input and routes it to the receiver.
// - Under receiver one, bit 2 pull-up equals value bit and not global disable.
// - Transmitter zero forces bit 1 to output with its data, pull-up off.
// - Receiver zero forces bit 0 to input; pull-up follows value bit, gated.
// - Bits 0 to 7 are pin change sources 24 to 31 in order.
// - Upper compare functions override value only; input kept by mask and group enable.
// - Lower receivers override pull-up and direction; transmitters override pull-up, direction, value.
// - Global pull-up disable turns every pull-up off, even input with value one.
module port_d_alternate_function_mux (
  input wire aclk,
  input wire aresetn,
  input wire [`AXI_ADDR_WIDTH-1:0] awaddr,
  input wire awvalid,
  output reg awready_ff,
  input wire [`AXI_DATA_WIDTH-1:0] wdata,
  input wire [`AXI_STRB_WIDTH-1:0] wstrb,
  input wire wvalid,
  output reg wready_ff,
  output reg [1:0] bresp_ff,
  output reg bvalid_ff,
  input wire bready,
  input wire [`AXI_ADDR_WIDTH-1:0] araddr,
  input wire arvalid,
  output reg arready_ff,
  output reg [`AXI_DATA_WIDTH-1:0] rdata_ff,
  output reg [1:0] rresp_ff,
  output reg rvalid_ff,
  input wire rready,
  input wire [`PORT_WIDTH-1:0] pad_in,
  output reg [`PORT_WIDTH-1:0] pad_out_ff,
  output reg [`PORT_WIDTH-1:0] pad_oe_ff,
  output reg [`PORT_WIDTH-1:0] pad_pullup_ff,
  input wire timer2_compare_a_out,
  input wire timer2_compare_a_enable,
  input wire timer2_compare_b_out,
  input wire timer2_compare_b_enable,
  input wire timer1_compare_a_out,
  input wire timer1_compare_a_enable,
  input wire timer1_compare_b_out,
  input wire timer1_compare_b_enable,
  input wire serial1_ext_clock_drive,
  input wire serial1_ext_clock_out,
  input wire serial0_tx_out,
  input wire serial0_tx_enable,
  input wire serial0_rx_enable,
  input wire serial1_tx_out,
  input wire serial1_tx_enable,
  input wire serial1_rx_enable,
  input wire ext_irq_line_0_enable,
  input wire ext_irq_line_1_enable,
  input wire sleep_input_disable,
  output reg timer1_capture_in_ff,
  output reg serial1_ext_clock_in_ff,
  output reg serial0_rx_in_ff,
  output reg serial1_rx_in_ff,
  output reg ext_irq_line_0_ff,
  output reg ext_irq_line_1_ff,
  output reg [`PORT_WIDTH-1:0] pin_change_src_ff,
  output reg pin_change_group3_enable_ff
);

  // --------------------------------------------------------------------------
  // Port registers
  // --------------------------------------------------------------------------
  reg [`PORT_WIDTH-1:0] out_value_ff;
  reg [`PORT_WIDTH-1:0] direction_ff;
  reg [`PORT_WIDTH-1:0] pc_mask_ff;
  reg global_pullup_disable_ff;

  // --------------------------------------------------------------------------
  // Write channel state
  // --------------------------------------------------------------------------
  reg aw_held_ff;
  reg w_held_ff;
  reg [`AXI_ADDR_WIDTH-1:0] aw_addr_ff;
  reg [`AXI_DATA_WIDTH-1:0] w_data_ff;
  reg [`AXI_STRB_WIDTH-1:0] w_strb_ff;

  wire do_write;
  wire write_mapped;
  wire read_mapped;
  reg [`AXI_DATA_WIDTH-1:0] nxt_rdata;

  // --------------------------------------------------------------------------
  // Override signal vectors, one bit per pin
  // --------------------------------------------------------------------------
  wire [`PORT_WIDTH-1:0] pullup_override_enable;
  wire [`PORT_WIDTH-1:0] pullup_override_value;
  wire [`PORT_WIDTH-1:0] direction_override_enable;
  wire [`PORT_WIDTH-1:0] direction_override_value;
  wire [`PORT_WIDTH-1:0] port_value_override_enable;
  wire [`PORT_WIDTH-1:0] port_value_override_value;
  wire [`PORT_WIDTH-1:0] input_enable_override_enable;
  wire [`PORT_WIDTH-1:0] input_enable_override_value;
  wire [`PORT_WIDTH-1:0] pin_sync;
  wire [`PORT_WIDTH-1:0] pin_dir;
  wire [`PORT_WIDTH-1:0] pin_value;
  wire [`PORT_WIDTH-1:0] pin_pullup;
  wire [`PORT_WIDTH-1:0] pin_input;
  wire [`PORT_WIDTH-1:0] pc_selected;
  wire rx1_pullup;
  wire rx0_pullup;

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign write_mapped = (aw_addr_ff == `OFS_OUT_VALUE) || (aw_addr_ff == `OFS_DIRECTION) ||
                        (aw_addr_ff == `OFS_PIN_INPUT) || (aw_addr_ff == `OFS_CONTROL) ||
                        (aw_addr_ff == `OFS_PC_MASK);

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= {`AXI_ADDR_WIDTH{1'b0}};
      w_data_ff <= {`AXI_DATA_WIDTH{1'b0}};
      w_strb_ff <= {`AXI_STRB_WIDTH{1'b0}};
    end else begin
      if (awvalid && awready_ff) begin
        aw_addr_ff <= awaddr;
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (wvalid && wready_ff) begin
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= write_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      // Both address and data ready reopen only after the response is taken.
      if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Only byte lane 0 carries register bits; the pin input register is read-only.
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_value_ff <= `RST_OUT_VALUE;
      direction_ff <= `RST_DIRECTION;
      pc_mask_ff <= `RST_PC_MASK;
      global_pullup_disable_ff <= 1'b0;
      pin_change_group3_enable_ff <= 1'b0;
    end else if (do_write && w_strb_ff[0]) begin
      case (aw_addr_ff)
        `OFS_OUT_VALUE: out_value_ff <= w_data_ff[`PORT_WIDTH-1:0];
        `OFS_DIRECTION: direction_ff <= w_data_ff[`PORT_WIDTH-1:0];
        `OFS_CONTROL: begin
          global_pullup_disable_ff <= w_data_ff[`CTRL_PUD_BIT];
          pin_change_group3_enable_ff <= w_data_ff[`CTRL_PCIE_BIT];
        end
        `OFS_PC_MASK: pc_mask_ff <= w_data_ff[`PORT_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  assign read_mapped = (araddr == `OFS_OUT_VALUE) || (araddr == `OFS_DIRECTION) ||
                       (araddr == `OFS_PIN_INPUT) || (araddr == `OFS_CONTROL) ||
                       (araddr == `OFS_PC_MASK);

  always @* begin
    nxt_rdata = {`AXI_DATA_WIDTH{1'b0}};
    case (araddr)
      `OFS_OUT_VALUE: nxt_rdata[`PORT_WIDTH-1:0] = out_value_ff;
      `OFS_DIRECTION: nxt_rdata[`PORT_WIDTH-1:0] = direction_ff;
      `OFS_PIN_INPUT: nxt_rdata[`PORT_WIDTH-1:0] = pin_input;
      `OFS_CONTROL: begin
        nxt_rdata[`CTRL_PUD_BIT] = global_pullup_disable_ff;
        nxt_rdata[`CTRL_PCIE_BIT] = pin_change_group3_enable_ff;
      end
      `OFS_PC_MASK: nxt_rdata[`PORT_WIDTH-1:0] = pc_mask_ff;
      default: nxt_rdata = {`AXI_DATA_WIDTH{1'b0}};
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= {`AXI_DATA_WIDTH{1'b0}};
      rresp_ff <= `RESP_OKAY;
    end else begin
      if (arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= nxt_rdata;
        rresp_ff <= read_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Override table, upper half: compare outputs and serial one clock
  // --------------------------------------------------------------------------
  // The waveform (plain compare or PWM) replaces the value only; direction stays with software.
  assign port_value_override_enable[`BIT_T2_CMP_A] = timer2_compare_a_enable;
  assign port_value_override_value[`BIT_T2_CMP_A] = timer2_compare_a_out;
  assign port_value_override_enable[`BIT_T2_CMP_B] = timer2_compare_b_enable;
  assign port_value_override_value[`BIT_T2_CMP_B] = timer2_compare_b_out;
  assign port_value_override_enable[`BIT_T1_CMP_A] = timer1_compare_a_enable;
  assign port_value_override_value[`BIT_T1_CMP_A] = timer1_compare_a_out;
  // Compare B has priority on bit 4; the serial clock drives it only when compare B is off.
  assign port_value_override_enable[`BIT_T1_CMP_B] = timer1_compare_b_enable | serial1_ext_clock_drive;
  assign port_value_override_value[`BIT_T1_CMP_B] = timer1_compare_b_enable ?
                                                    timer1_compare_b_out : serial1_ext_clock_out;

  // --------------------------------------------------------------------------
  // Override table, lower half: serial transmit and receive
  // --------------------------------------------------------------------------
  assign rx1_pullup = out_value_ff[`BIT_S1_RX] & ~global_pullup_disable_ff;
  assign rx0_pullup = out_value_ff[`BIT_S0_RX] & ~global_pullup_disable_ff;

  assign pullup_override_enable = {4'h0, serial1_tx_enable, serial1_rx_enable,
                                   serial0_tx_enable, serial0_rx_enable};
  assign pullup_override_value = {4'h0, 1'b0, rx1_pullup, 1'b0, rx0_pullup};
  assign direction_override_enable = {4'h0, serial1_tx_enable, serial1_rx_enable,
                                      serial0_tx_enable, serial0_rx_enable};
  assign direction_override_value = 8'h0A;
  assign port_value_override_enable[3:0] = {serial1_tx_enable, 1'b0, serial0_tx_enable, 1'b0};
  assign port_value_override_value[3:0] = {serial1_tx_out, 1'b0, serial0_tx_out, 1'b0};

  // --------------------------------------------------------------------------
  // Digital input enable: kept on for armed pin change and interrupt lines
  // --------------------------------------------------------------------------
  assign pc_selected = pc_mask_ff & {`PORT_WIDTH{pin_change_group3_enable_ff}};
  assign input_enable_override_enable = pc_selected |
                                        ({{(`PORT_WIDTH-1){1'b0}}, ext_irq_line_1_enable} << `BIT_IRQ1) |
                                        ({{(`PORT_WIDTH-1){1'b0}}, ext_irq_line_0_enable} << `BIT_IRQ0);
  assign input_enable_override_value = {`PORT_WIDTH{1'b1}};

  // --------------------------------------------------------------------------
  // Pin cells
  // --------------------------------------------------------------------------
  sync_two_stage u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pad_in),
    .sync_out(pin_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `PORT_WIDTH; gi = gi + 1) begin : g_pin
      pin_override_cell u_cell (
        .dir_reg(direction_ff[gi]),
        .out_reg(out_value_ff[gi]),
        .global_pullup_disable(global_pullup_disable_ff),
        .sleep_input_disable(sleep_input_disable),
        .pullup_override_enable(pullup_override_enable[gi]),
        .pullup_override_value(pullup_override_value[gi]),
        .direction_override_enable(direction_override_enable[gi]),
        .direction_override_value(direction_override_value[gi]),
        .port_value_override_enable(port_value_override_enable[gi]),
        .port_value_override_value(port_value_override_value[gi]),
        .input_enable_override_enable(input_enable_override_enable[gi]),
        .input_enable_override_value(input_enable_override_value[gi]),
        .pin_level(pin_sync[gi]),
        .pin_dir(pin_dir[gi]),
        .pin_value(pin_value[gi]),
        .pin_pullup(pin_pullup[gi]),
        .pin_input(pin_input[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Registered outputs to the pads and to the peripherals
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_ff <= {`PORT_WIDTH{1'b0}};
      pad_oe_ff <= {`PORT_WIDTH{1'b0}};
      pad_pullup_ff <= {`PORT_WIDTH{1'b0}};
      timer1_capture_in_ff <= 1'b0;
      serial1_ext_clock_in_ff <= 1'b0;
      serial0_rx_in_ff <= 1'b0;
      serial1_rx_in_ff <= 1'b0;
      ext_irq_line_0_ff <= 1'b0;
      ext_irq_line_1_ff <= 1'b0;
      pin_change_src_ff <= {`PORT_WIDTH{1'b0}};
    end else begin
      // Without the direction bit (or a forced output) the value never reaches the pad.
      pad_out_ff <= pin_value;
      pad_oe_ff <= pin_dir;
      pad_pullup_ff <= pin_pullup;
      timer1_capture_in_ff <= pin_input[`BIT_T1_CAPTURE];
      serial1_ext_clock_in_ff <= pin_input[`BIT_S1_XCLK];
      serial0_rx_in_ff <= pin_input[`BIT_S0_RX];
      serial1_rx_in_ff <= pin_input[`BIT_S1_RX];
      ext_irq_line_0_ff <= pin_input[`BIT_IRQ0];
      ext_irq_line_1_ff <= pin_input[`BIT_IRQ1];
      // Source n of the port is pin change source base plus n.
      pin_change_src_ff <= pin_input & pc_selected;
    end
  end

endmodule // port_d_alternate_function_mux

`default_nettype wire

// file: sim/periph_model.sv
// Behavioural timers and serial transmitters on the far side of the multiplexer.
`timescale 1ns/1ns
`default_nettype none
module periph_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [6:0] wave
);
  logic [7:0] cnt_ff;
  always @(posedge aclk) cnt_ff <= aresetn ? cnt_ff + 8'h01 : 8'h00;
  // Each compare channel has its own duty cycle, so a swapped route cannot hide.
  assign wave[6:3] = {cnt_ff[3:0] < 4'h3, cnt_ff[3:0] < 4'hB, cnt_ff[2], cnt_ff[4:1] < 4'h6};
  assign wave[2:0] = {cnt_ff[1] ^ cnt_ff[6], cnt_ff[0] ^ cnt_ff[5], cnt_ff[0]};
endmodule // periph_model
`default_nettype wire

// file: sim/pdm_check_sva.sv
// Concurrent checks on the pin side of the port D multiplexer.
`timescale 1ns/1ns
`default_nettype none
module pdm_check (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_out_ff,
  input wire logic [7:0] pad_oe_ff,
  input wire logic [7:0] pad_pullup_ff,
  input wire logic timer2_compare_a_out,
  input wire logic timer2_compare_a_enable,
  input wire logic timer1_compare_b_out,
  input wire logic timer1_compare_b_enable,
  input wire logic serial0_tx_out,
  input wire logic serial0_tx_enable,
  input wire logic serial0_rx_enable,
  input wire logic serial1_tx_out,
  input wire logic serial1_tx_enable,
  input wire logic serial1_rx_enable,
  input wire logic ext_irq_line_1_enable,
  input wire logic ext_irq_line_1_ff,
  input wire logic [7:0] pin_change_src_ff,
  input wire logic pin_change_group3_enable_ff
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_tx1_force: assert property ($past(aresetn && serial1_tx_enable) |-> pad_oe_ff[3] && !pad_pullup_ff[3]
    && pad_out_ff[3] == $past(serial1_tx_out)) else $error("tx1 pin not forced");
  a_tx0_force: assert property ($past(aresetn && serial0_tx_enable) |-> pad_oe_ff[1] && !pad_pullup_ff[1]
    && pad_out_ff[1] == $past(serial0_tx_out)) else $error("tx0 pin not forced");
  a_rx1_input: assert property ($past(aresetn && serial1_rx_enable) |-> !pad_oe_ff[2]) else $error("rx1 driven");
  a_rx0_input: assert property ($past(aresetn && serial0_rx_enable) |-> !pad_oe_ff[0]) else $error("rx0 driven");
  a_cmp_t2a: assert property ($past(aresetn && timer2_compare_a_enable) |->
    pad_out_ff[7] == $past(timer2_compare_a_out)) else $error("compare 2A not on pin");
  a_cmp_t1b: assert property ($past(aresetn && timer1_compare_b_enable) |->
    pad_out_ff[4] == $past(timer1_compare_b_out)) else $error("compare 1B not on pin");
  a_irq1_path: assert property (ext_irq_line_1_enable [*4] |->
    ext_irq_line_1_ff == $past(pad_in[3], 3)) else $error("irq1 input path wrong");
  a_pc_group: assert property (!pin_change_group3_enable_ff && !$past(pin_change_group3_enable_ff) |->
    pin_change_src_ff == 8'h00) else $error("pin change live with group off");
endmodule // pdm_check
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the port D multiplexer and its register bus.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [7:0] awaddr, araddr, pad_in, pad_out_ff, pad_oe_ff, pad_pullup_ff, pin_change_src_ff, out_sh, dir_sh, msk_sh;
  logic [31:0] wdata, rdata_ff;
  logic [3:0] wstrb;
  logic [1:0] bresp_ff, rresp_ff, ctl_sh;
  logic timer2_compare_a_out, timer2_compare_a_enable, timer2_compare_b_out, timer2_compare_b_enable;
  logic timer1_compare_a_out, timer1_compare_a_enable, timer1_compare_b_out, timer1_compare_b_enable;
  logic serial1_ext_clock_drive, serial1_ext_clock_out, serial0_tx_out, serial0_tx_enable, serial0_rx_enable;
  logic serial1_tx_out, serial1_tx_enable, serial1_rx_enable, ext_irq_line_0_enable, ext_irq_line_1_enable;
  logic sleep_input_disable, timer1_capture_in_ff, serial1_ext_clock_in_ff, serial0_rx_in_ff, serial1_rx_in_ff;
  logic ext_irq_line_0_ff, ext_irq_line_1_ff, pin_change_group3_enable_ff;
  int err_total = 0;
  int total_checks = 0;
  always #25 aclk = ~aclk;
  port_d_alternate_function_mux dut (.*);
  periph_model peer (.aclk(aclk), .aresetn(aresetn), .wave({timer2_compare_a_out, timer2_compare_b_out,
    timer1_compare_a_out, timer1_compare_b_out, serial0_tx_out, serial1_tx_out, serial1_ext_clock_out}));
  task automatic end_of_test(input int lost);
    err_total += lost;
    $display("mismatches=%0d checks=%0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      n++;
      if (awready_ff === 1'b1) awvalid <= 1'b0;
      if (wready_ff === 1'b1) wvalid <= 1'b0;
    end while (bvalid_ff !== 1'b1 && n < 40);
    bready <= 1'b0;
    if (n >= 40) end_of_test(1);
    chk(32'(bresp_ff), 32'(er));
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (arready_ff === 1'b1) arvalid <= 1'b0;
    end while (rvalid_ff !== 1'b1 && n < 40);
    rready <= 1'b0;
    if (n >= 40) end_of_test(1);
    chk(rdata_ff, e);
    chk(32'(rresp_ff), 32'(er));
  endtask
  function automatic logic [23:0] exp_pad();
    logic [7:0] oe, v, pu;
    logic [3:0] ce;
    ce = {timer2_compare_a_enable, timer2_compare_b_enable, timer1_compare_a_enable, timer1_compare_b_enable};
    oe = dir_sh;
    v = out_sh;
    pu = ~dir_sh & out_sh & {8{~ctl_sh[0]}};
    if (serial1_ext_clock_drive) v[4] = serial1_ext_clock_out;
    v[7:4] = (ce & ~v[7:4] | v[7:4]) & (~ce | {timer2_compare_a_out, timer2_compare_b_out,
      timer1_compare_a_out, timer1_compare_b_out});
    if (serial1_rx_enable) {oe[2], pu[2]} = {1'b0, out_sh[2] & ~ctl_sh[0]};
    if (serial0_rx_enable) {oe[0], pu[0]} = {1'b0, out_sh[0] & ~ctl_sh[0]};
    if (serial1_tx_enable) {oe[3], v[3], pu[3]} = {1'b1, serial1_tx_out, 1'b0};
    if (serial0_tx_enable) {oe[1], v[1], pu[1]} = {1'b1, serial0_tx_out, 1'b0};
    return {oe, v, pu};
  endfunction
  task automatic pad_step();
    logic [23:0] e;
    @(posedge aclk);
    {timer2_compare_a_enable, timer2_compare_b_enable, timer1_compare_a_enable, timer1_compare_b_enable,
      serial1_ext_clock_drive, serial0_tx_enable, serial0_rx_enable, serial1_tx_enable, serial1_rx_enable,
      ext_irq_line_1_enable, pad_in} <= 18'($urandom);
    #1;
    e = exp_pad();
    @(posedge aclk);
    #1;
    chk({8'h00, pad_oe_ff, pad_out_ff, pad_pullup_ff}, {8'h00, e});
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, pad_in, sleep_input_disable} = '0;
    {timer2_compare_a_enable, timer2_compare_b_enable, timer1_compare_a_enable, timer1_compare_b_enable} = '0;
    {serial1_ext_clock_drive, serial0_tx_enable, serial0_rx_enable, serial1_tx_enable, serial1_rx_enable} = '0;
    {ext_irq_line_0_enable, ext_irq_line_1_enable} = '0;
    wstrb = 4'hF;
    void'($urandom(32'hB4AC));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rc(8'(i * 4), 32'h0, i == 5 ? 2'h2 : 2'h0);
    wr(8'h14, 32'hFF, 2'h2);
    wr(8'h08, 32'hFF, 2'h0);
    wstrb <= 4'hE;
    wr(8'h00, 32'hFF, 2'h0);
    wstrb <= 4'hF;
    rc(8'h00, 32'h0, 2'h0);
    for (int i = 0; i < 8; i++) begin
      out_sh = i < 2 ? 8'hFF : 8'($urandom);
      dir_sh = i < 2 ? 8'h00 : 8'($urandom);
      ctl_sh = i < 2 ? 2'(i) : 2'($urandom);
      wr(8'h00, 32'(out_sh), 2'h0);
      wr(8'h04, 32'(dir_sh), 2'h0);
      wr(8'h0C, 32'(ctl_sh), 2'h0);
      rc(8'h0C, 32'(ctl_sh), 2'h0);
      repeat (30) pad_step();
    end
    for (int i = 0; i < 4; i++) begin
      msk_sh = 8'($urandom);
      wr(8'h10, 32'(msk_sh), 2'h0);
      wr(8'h0C, 32'({i[0], 1'b0}), 2'h0);
      pad_in <= 8'($urandom);
      repeat (4) @(posedge aclk);
      #1;
      chk(32'({pin_change_group3_enable_ff, pin_change_src_ff}),
        32'({i[0], pad_in & msk_sh & {8{i[0]}}}));
      chk({serial0_rx_in_ff, serial1_rx_in_ff, timer1_capture_in_ff, serial1_ext_clock_in_ff, ext_irq_line_0_ff,
        ext_irq_line_1_ff}, {pad_in[0], pad_in[2], pad_in[6], pad_in[4], pad_in[2], pad_in[3]});
      rc(8'h08, 32'(pad_in), 2'h0);
    end
    wr(8'h10, 32'h40, 2'h0);
    {sleep_input_disable, ext_irq_line_0_enable, ext_irq_line_1_enable, pad_in} <= 11'h7FF;
    repeat (4) @(posedge aclk);
    #1;
    chk({ext_irq_line_0_ff, ext_irq_line_1_ff, timer1_capture_in_ff, serial0_rx_in_ff}, 32'hE);
    end_of_test(0);
  end
endmodule // tb_top
bind port_d_alternate_function_mux pdm_check chk_i (.*);
`default_nettype wire
